// File: rrsp_pkg.sv
// Package for the remote register setpoint command block.
// Assumes a single 10 MHz system clock and word-wide remote register writes.
package rrsp_pkg;

  // ----------------------------------------
  // Remote word offsets
  // ----------------------------------------
  localparam logic [3:0] RRSP_OFF_POS_LO = 4'h4;
  localparam logic [3:0] RRSP_OFF_POS_HI = 4'h5;
  localparam logic [3:0] RRSP_OFF_SPEED  = 4'h6;

  // ----------------------------------------
  // Parameter digit codes and limits
  // ----------------------------------------
  localparam logic [3:0] RRSP_CMD_ABS        = 4'h0;
  localparam logic [3:0] RRSP_CMD_INC        = 4'h1;
  localparam logic [3:0] RRSP_SRC_REMOTE     = 4'h2;
  localparam logic [1:0] RRSP_STATIONS_REQ   = 2'h2;
  localparam logic signed [31:0] RRSP_POS_MAX = 32'sd999999;
  localparam logic signed [31:0] RRSP_POS_MIN = -32'sd999999;
  localparam logic signed [31:0] RRSP_INC_MIN = 32'sd0;
  localparam logic [3:0] RRSP_ACCEL_TABLE    = 4'h1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RRSP_WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    RRSP_IDLE  = 3'b001,
    RRSP_CHECK = 3'b010,
    RRSP_ISSUE = 3'b100
  } rrsp_state_t;

endpackage

// File: rrsp_word_if.sv
// Interface carrying remote word writes between the top and the word store.
// Assumes the writer and store share clk_sys_in.
interface rrsp_word_if;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [15:0] wr_data;
  logic [15:0] pos_lo;
  logic [15:0] pos_hi;
  logic [15:0] speed;
  modport writer (output wr_en, output wr_addr, output wr_data,
                  input pos_lo, input pos_hi, input speed);
  modport store  (input wr_en, input wr_addr, input wr_data,
                  output pos_lo, output pos_hi, output speed);
endinterface

// File: rrsp_word_store.sv
// Holding registers for the three remote setpoint words.
// Assumes synchronous reset copy from the top module.
module rrsp_word_store (
  // Clock and reset
  input  wire logic   clk_sys_in,
  input  wire logic   rst_b_in,
  // Word port
  rrsp_word_if.store  word_if
);
  import rrsp_pkg::*;

  logic [15:0] pos_lo_q;
  logic [15:0] pos_hi_q;
  logic [15:0] speed_q;

  wire sel_lo = word_if.wr_en && (word_if.wr_addr == RRSP_OFF_POS_LO);
  wire sel_hi = word_if.wr_en && (word_if.wr_addr == RRSP_OFF_POS_HI);
  wire sel_sp = word_if.wr_en && (word_if.wr_addr == RRSP_OFF_SPEED);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos_lo_q <= RRSP_WORD_RST;
      pos_hi_q <= RRSP_WORD_RST;
      speed_q  <= RRSP_WORD_RST;
    end else begin
      if (sel_lo) pos_lo_q <= word_if.wr_data;
      if (sel_hi) pos_hi_q <= word_if.wr_data;
      if (sel_sp) speed_q  <= word_if.wr_data;
    end
  end

  assign word_if.pos_lo = pos_lo_q;
  assign word_if.pos_hi = pos_hi_q;
  assign word_if.speed  = speed_q;
endmodule // rrsp_word_store

// File: rrsp_setpoint.sv
// Remote register setpoint acceptance: latches a move on forward start.
// Assumes master inputs synchronous to clk_sys_in; parameters held static.
//
// Overview of operation
// - Remote-word setpoints are only usable when the node occupies two stations.
// - Setpoints come from remote words only with auto mode and remote source both selected.
// - The setpoint source parameter low digit must be 2 to enable remote setpoints.
// - Command system digit 0 selects absolute mode where the abs/inc bit decides meaning.
// - Command system digit 1 selects incremental mode where every position is relative.
// - In incremental mode the abs/inc bit is ignored.
// - In absolute mode the position is absolute with the bit off and incremental with it on.
// - The abs/inc bit is sampled when forward start rises and held for that move.
// - Incremental mode with remote setpoints uses point table one time constants.
module rrsp_setpoint (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Remote word writes
  input  wire logic        word_wr_in,
  input  wire logic [3:0]  word_addr_in,
  input  wire logic [15:0] word_data_in,
  // Remote bits
  input  wire logic        auto_manual_select_in,
  input  wire logic        setpoint_source_select_in,
  input  wire logic        abs_inc_select_in,
  input  wire logic        forward_start_in,
  // Configuration
  input  wire logic [1:0]  stations_in,
  input  wire logic [3:0]  command_system_param_in,
  input  wire logic [3:0]  setpoint_source_param_in,
  // Move command
  output logic             move_start_out,
  output logic signed [31:0] move_position_out,
  output logic [15:0]      move_speed_out,
  output logic             move_incremental_out,
  output logic             move_use_table_out,
  output logic [3:0]       move_accel_table_out,
  output logic             range_error_out,
  output logic             remote_active_out
);
  import rrsp_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_b = rst_s2_q;

  // ----------------------------------------
  // Word store
  // ----------------------------------------
  rrsp_word_if word_if ();
  assign word_if.wr_en   = word_wr_in;
  assign word_if.wr_addr = word_addr_in;
  assign word_if.wr_data = word_data_in;

  rrsp_word_store u_store (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b),
    .word_if    (word_if)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire two_station  = (stations_in == RRSP_STATIONS_REQ);
  wire src_remote   = (setpoint_source_param_in == RRSP_SRC_REMOTE);
  wire remote_en    = two_station && src_remote && auto_manual_select_in
                      && setpoint_source_select_in;
  wire cmd_inc      = (command_system_param_in == RRSP_CMD_INC);
  wire cmd_abs      = (command_system_param_in == RRSP_CMD_ABS);
  wire mode_ok      = cmd_inc || cmd_abs;
  wire treat_inc    = cmd_inc || abs_inc_select_in;
  wire signed [31:0] pos_word = $signed({word_if.pos_hi, word_if.pos_lo});
  wire pos_ok_abs   = (pos_word >= RRSP_POS_MIN) && (pos_word <= RRSP_POS_MAX);
  wire pos_ok_inc   = (pos_word >= RRSP_INC_MIN) && (pos_word <= RRSP_POS_MAX);
  wire pos_ok       = cmd_inc ? pos_ok_inc : pos_ok_abs;

  logic start_q;
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) start_q <= 1'b0;
    else        start_q <= forward_start_in;
  end
  wire start_rise = forward_start_in && !start_q;

  // ----------------------------------------
  // Acceptance state machine
  // ----------------------------------------
  rrsp_state_t state_q;
  rrsp_state_t state_d;
  logic        inc_q;
  logic signed [31:0] pos_q;
  logic [15:0] speed_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      RRSP_IDLE:  if (start_rise && remote_en && mode_ok) state_d = RRSP_CHECK;
      RRSP_CHECK: state_d = RRSP_ISSUE;
      RRSP_ISSUE: state_d = RRSP_IDLE;
      default:    state_d = RRSP_IDLE;
    endcase
  end

  wire take  = (state_q == RRSP_IDLE) && (state_d == RRSP_CHECK);
  wire check = (state_q == RRSP_CHECK);
  wire issue = (state_q == RRSP_ISSUE);
  logic err_q;

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RRSP_IDLE;
      inc_q   <= 1'b0;
      pos_q   <= '0;
      speed_q <= RRSP_WORD_RST;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        inc_q   <= treat_inc;
        pos_q   <= pos_word;
        speed_q <= word_if.speed;
        err_q   <= !pos_ok;
      end
    end
  end

  // ----------------------------------------
  // Move outputs
  // ----------------------------------------
  logic move_start_q;
  logic use_tab_q;
  logic rerr_q;
  logic signed [31:0] mpos_q;
  logic [15:0] mspd_q;
  logic minc_q;
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      move_start_q <= 1'b0;
      use_tab_q    <= 1'b0;
      rerr_q       <= 1'b0;
      mpos_q       <= '0;
      mspd_q       <= RRSP_WORD_RST;
      minc_q       <= 1'b0;
    end else begin
      move_start_q <= check && !err_q;
      if (check) rerr_q <= err_q;
      if (check && !err_q) begin
        mpos_q    <= pos_q;
        mspd_q    <= speed_q;
        minc_q    <= inc_q;
        use_tab_q <= cmd_inc;
      end
    end
  end

  assign move_start_out       = move_start_q;
  assign move_position_out    = mpos_q;
  assign move_speed_out       = mspd_q;
  assign move_incremental_out = minc_q;
  assign move_use_table_out   = use_tab_q;
  assign move_accel_table_out = RRSP_ACCEL_TABLE;
  assign range_error_out      = rerr_q;
  assign remote_active_out    = remote_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_take;
    start_rise && remote_en && mode_ok && state_q == RRSP_IDLE;
  endsequence
  sequence s_issue_ok;
    ##2 (move_start_out || range_error_out);
  endsequence

  chk_start_after_take: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    s_take |-> s_issue_ok) else $error("move not issued two cycles after start");
  chk_no_start_bad: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    move_start_out |-> $past(two_station, 2)) else $error("move without two stations");
  chk_src_param: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    move_start_out |-> $past(src_remote, 2)) else $error("move without remote source");
  chk_inc_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    (s_take and cmd_inc) |-> ##2 (!move_start_out || move_incremental_out))
    else $error("incremental mode move not relative");
  chk_abs_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    (s_take and cmd_abs) |-> ##2 (!move_start_out ||
      move_incremental_out == $past(abs_inc_select_in, 2)))
    else $error("abs mode interpretation wrong");
  chk_range_abs: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    move_start_out |-> (move_position_out <= RRSP_POS_MAX && move_position_out >= RRSP_POS_MIN))
    else $error("position out of range issued");
  chk_range_inc: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    (move_start_out && $past(cmd_inc, 2)) |-> move_position_out >= RRSP_INC_MIN)
    else $error("negative incremental position issued");
  chk_table_one: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    move_start_out |-> move_use_table_out == $past(cmd_inc, 2)) else $error("table use wrong");
  chk_pos_join: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    s_take |-> ##2 (!move_start_out || move_position_out == $past(pos_word, 2)))
    else $error("position words not joined");
  chk_remote_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    move_start_out |-> $past(remote_en, 2)) else $error("move without remote selection");
  chk_inc_held: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    !move_start_out |-> $stable(move_incremental_out)) else $error("move interpretation changed");
  // Start pulse must drop once the issue cycle is over
  chk_pulse_once: assert property (@(posedge clk_sys_in) disable iff (!rst_b)
    issue |=> !move_start_out) else $error("move start longer than one cycle");
endmodule // rrsp_setpoint

// File: rrsp_master_model.sv
// Fieldbus master model: writes remote words and drives the remote bits.
// Assumes the bench calls its tasks; every change lands on a falling edge.
module rrsp_master_model (
  // Clock
  input  wire logic   clk_sys_in,
  // Remote word writes
  output logic        word_wr_out,
  output logic [3:0]  word_addr_out,
  output logic [15:0] word_data_out,
  // Remote bits
  output logic        auto_out,
  output logic        src_out,
  output logic        abs_inc_out,
  output logic        start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    word_wr_out   = 1'b0;
    word_addr_out = 4'h0;
    word_data_out = 16'h0000;
    auto_out      = 1'b0;
    src_out       = 1'b0;
    abs_inc_out   = 1'b0;
    start_out     = 1'b0;
  end
  // Idle data shows the inverse so stale values never look valid
  task automatic write_word(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    word_wr_out   <= 1'b1;
    word_addr_out <= a;
    word_data_out <= d;
    @(negedge clk_sys_in);
    word_wr_out   <= 1'b0;
    word_data_out <= ~d;
  endtask
  task automatic write_pos(input logic signed [31:0] p);
    write_word(4'h4, p[15:0]);
    write_word(4'h5, p[31:16]);
  endtask
  // Selections settle a full cycle before any start
  task automatic set_bits(input logic a, input logic s, input logic b);
    @(negedge clk_sys_in);
    auto_out    <= a;
    src_out     <= s;
    abs_inc_out <= b;
    @(negedge clk_sys_in);
  endtask
  // Optional flip of the select bit just after the start is taken
  task automatic pulse_start(input logic flip);
    @(negedge clk_sys_in);
    start_out <= 1'b1;
    @(negedge clk_sys_in);
    start_out <= 1'b0;
    if (flip) begin
      abs_inc_out <= ~abs_inc_out;
    end
  endtask
endmodule // rrsp_master_model

// File: remote_register_setpoint_tb.sv
// Self-checking bench for the remote register setpoint block.
// Assumes the master model drives all remote traffic on falling edges.
module remote_register_setpoint_tb;
  import rrsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, rst_b_in, wr, auto_sel, src_sel, ai_sel, fstart, go, err, inc, tab, act;
  logic [3:0] addr, tbl, cmd_q, srcp_q;
  logic [15:0] data, spd_out, spd;
  logic [1:0] stn_q;
  logic signed [31:0] pos_out;
  int num_errors = 0;
  int n_checks = 0;
  int starts = 0;
  rrsp_master_model i_master (.clk_sys_in(clk_sys_in), .word_wr_out(wr), .word_addr_out(addr),
    .word_data_out(data), .auto_out(auto_sel), .src_out(src_sel), .abs_inc_out(ai_sel),
    .start_out(fstart));
  rrsp_setpoint i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .word_wr_in(wr),
    .word_addr_in(addr), .word_data_in(data), .auto_manual_select_in(auto_sel),
    .setpoint_source_select_in(src_sel), .abs_inc_select_in(ai_sel),
    .forward_start_in(fstart), .stations_in(stn_q), .command_system_param_in(cmd_q),
    .setpoint_source_param_in(srcp_q), .move_start_out(go), .move_position_out(pos_out),
    .move_speed_out(spd_out), .move_incremental_out(inc), .move_use_table_out(tab),
    .move_accel_table_out(tbl), .range_error_out(err), .remote_active_out(act));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) if (go === 1'b1) starts++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One start, then the issued move compared with what is expected
  task automatic run(input logic flip, input logic eg, input logic ee,
                     input logic [31:0] ep, input logic ei);
    int s0;
    s0 = starts;
    i_master.pulse_start(flip);
    repeat (5) @(negedge clk_sys_in);
    check("start_count", 32'(starts - s0), {31'h0, eg});
    check("range_error", {31'h0, err}, {31'h0, ee});
    if (eg) begin
      check("position", pos_out, ep);
      check("incremental", {31'h0, inc}, {31'h0, ei});
      check("use_table", {31'h0, tab}, {31'h0, cmd_q == RRSP_CMD_INC});
      check("speed", {16'h0, spd_out}, {16'h0, spd});
      check("accel_table", {28'h0, tbl}, {28'h0, RRSP_ACCEL_TABLE});
    end
  endtask
  task automatic speed(input logic [15:0] v);
    spd = v;
    i_master.write_word(RRSP_OFF_SPEED, v);
  endtask
  initial begin
    #(5000 * 100);
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_b_in = 1'b0;
    stn_q    = 2'h2;
    cmd_q    = RRSP_CMD_ABS;
    srcp_q   = RRSP_SRC_REMOTE;
    spd      = 16'h0000;
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    i_master.set_bits(1'b1, 1'b1, 1'b0);
    check("remote_active", {31'h0, act}, 32'h1);
    i_master.write_pos(999999);
    speed(16'h0bb8);
    run(1'b0, 1'b1, 1'b0, 999999, 1'b0);
    i_master.write_pos(-999999);
    speed(16'h07d0);
    i_master.set_bits(1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b1, 1'b0, -999999, 1'b1);
    i_master.write_pos(-1000000);
    run(1'b0, 1'b0, 1'b1, 0, 1'b0);
    i_master.write_pos(32'h0001_2345);
    i_master.write_word(4'h7, 16'hffff);
    i_master.write_word(4'h3, 16'hffff);
    run(1'b0, 1'b1, 1'b0, 32'h0001_2345, 1'b0);
    for (int k = 0; k < 4; k++) begin
      stn_q  = (k == 0) ? 2'h1 : 2'h2;
      srcp_q = (k == 3) ? 4'h3 : RRSP_SRC_REMOTE;
      i_master.set_bits(k != 1, k != 2, 1'b0);
      check("remote_active", {31'h0, act}, 32'h0);
      run(1'b0, 1'b0, 1'b0, 0, 1'b0);
    end
    stn_q  = 2'h2;
    srcp_q = RRSP_SRC_REMOTE;
    cmd_q  = RRSP_CMD_INC;
    i_master.set_bits(1'b1, 1'b1, 1'b0);
    i_master.write_pos(0);
    run(1'b0, 1'b1, 1'b0, 0, 1'b1);
    i_master.write_pos(999999);
    run(1'b0, 1'b1, 1'b0, 999999, 1'b1);
    cmd_q = 4'h2;
    run(1'b0, 1'b0, 1'b0, 0, 1'b0);
    cmd_q = RRSP_CMD_INC;
    i_master.write_pos(-1);
    run(1'b0, 1'b0, 1'b1, 0, 1'b0);
    i_master.write_pos(1000000);
    run(1'b0, 1'b0, 1'b1, 0, 1'b0);
    print_verdict();
  end
endmodule // remote_register_setpoint_tb
